// [hw/msd_pkg.sv]
package msd_pkg;
  localparam int REG_W = 16;
  localparam int NUM_MSEL = 18;
  localparam int NUM_PROG = 4;
  localparam int NUM_PSEL = 16;
  localparam int BASE_W = 22;
  // register byte addresses
  localparam logic [31:0] OFS_STATIC_MEMORY_TIMING = 32'hffff_fd00;
  localparam logic [31:0] OFS_WRITE_POSTING_CONTROL = 32'hffff_fd2c;
  localparam logic [31:0] OFS_PERIPHERAL_WRITE_CONTROL = 32'hffff_fd30;
  localparam logic [31:0] OFS_PERIPHERAL_EXTERNAL_MAP = 32'hffff_fd34;
  localparam logic [31:0] OFS_PPROT = 32'hffff_fd38;
  localparam logic [31:0] OFS_HI0 = 32'hffff_fe00;
  localparam logic [31:0] OFS_LO0 = 32'hffff_fe04;
  localparam logic [31:0] OFS_HI1 = 32'hffff_fe08;
  localparam logic [31:0] OFS_LO1 = 32'h0fff_fe0c;
  localparam logic [31:0] OFS_HI2 = 32'hffff_fe10;
  localparam logic [31:0] OFS_LO2 = 32'h0fff_fe14;
  localparam logic [31:0] OFS_HI3 = 32'hffff_fe18;
  localparam logic [31:0] OFS_LO3 = 32'h0fff_fe1c;
  localparam logic [31:0] OFS_HI4 = 32'hffff_fe20;
  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_HI4 = 16'h0002;
  // writable bits
  localparam logic [15:0] WMASK_STATIC_MEMORY_TIMING = 16'h3ef3;
  localparam logic [15:0] WMASK_WRITE_POSTING_CONTROL = 16'h0003;
  localparam logic [15:0] WMASK_PERIPHERAL_WRITE_CONTROL = 16'h0001;
  localparam logic [15:0] WMASK_LO0 = 16'hfdf3;
  localparam logic [15:0] WMASK_LO = 16'hfef3;
  // static_memory_timing fields
  localparam int WRITE_SETUP_CYCLES_LSB = 12;
  localparam int TRAIL_LSB = 9;
  localparam int ACTIVE_LSB = 4;
  localparam int ENDIAN_BIT = 3;
  localparam int WIDTH_LSB = 0;
  localparam logic [1:0] WIDTH_RSVD = 2'h3;
  // write_posting_control / peripheral_write_control fields
  localparam int OVR_BIT = 1;
  localparam int POST_BIT = 0;
  // fine base low fields
  localparam int BASE_LO_LSB = 10;
  localparam int AW_BIT = 9;
  localparam int MAP_BIT = 8;
  localparam int SIZE_LSB = 4;
  localparam int RO_BIT = 1;
  localparam int SUPERVISOR_ONLY_BIT = 0;
  // fixed selects are 1Kx32, i.e. 4K bytes
  localparam logic [3:0] FIXED_SIZE = 4'h3;
  localparam int FIXED_HI_OFS = 2;
  // peripheral window: 16 slots of 1K bytes
  localparam int PSEL_IDX_LSB = 10;
  localparam int PSEL_TAG_LSB = 14;
  localparam int CNT_W = 5;
endpackage

// [hw/msd_region_match.sv]
`timescale 1ns/1ps
`default_nettype none
module msd_region_match (
  input wire logic [21:0] i_base,
  input wire logic [3:0] i_size,
  input wire logic [31:0] i_addr,
  output logic o_hit
);
  logic [21:0] mask;
  always_comb begin
    // size code n covers 2^(n-1) K bytes: low n-1 base bits are don't care
    if (i_size == 4'h0) begin
      mask = '0;
    end else begin
      mask = ~((22'h00_0001 << (i_size - 4'h1)) - 22'h00_0001);
    end
    o_hit = (i_size != 4'h0) && (((i_addr[31:10] ^ i_base) & mask) == '0);
  end
endmodule
`default_nettype wire

// [hw/msd_access_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module msd_access_timer #(
  parameter int CW = msd_pkg::CNT_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [1:0] i_setup,
  input wire logic [CW-1:0] i_active,
  input wire logic [2:0] i_trail,
  output logic o_busy,
  output logic o_strobe,
  output logic o_done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_ACT = 2'b10,
    ST_TRAIL = 2'b11
  } msd_phase_e;
  msd_phase_e state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] act_reg;
  logic [2:0] trail_reg;
  logic wr_reg;

  initial begin
    if (CW < 5) $error("counter too narrow for wait states");
  end

  assign o_busy = (state_reg != ST_IDLE);
  assign o_strobe = (state_reg == ST_ACT) && wr_reg;
  assign o_done = (cnt_reg == '0) && ((state_reg == ST_TRAIL) ||
                  ((state_reg == ST_ACT) && (trail_reg == 3'h0)));

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      act_reg <= '0;
      trail_reg <= '0;
      wr_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (i_start) begin
            act_reg <= i_active;
            trail_reg <= i_trail;
            wr_reg <= i_write;
            // setup delays only the write strobe
            if (i_write && (i_setup != 2'h0)) begin
              state_reg <= ST_SETUP;
              cnt_reg <= CW'(i_setup - 2'h1);
            end else begin
              state_reg <= ST_ACT;
              cnt_reg <= i_active - CW'(1);
            end
          end
        end
        ST_SETUP: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_ACT;
            cnt_reg <= act_reg - CW'(1);
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        ST_ACT: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CW'(1);
          end else if (trail_reg != 3'h0) begin
            state_reg <= ST_TRAIL;
            cnt_reg <= CW'(trail_reg - 3'h1);
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_TRAIL: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/msd_memory_select_decode_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module msd_memory_select_decode_ctrl #(
  parameter logic [17:0] PSEL_TAG = 18'h3_ffdf
) (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_LITTLE_ENDIAN,
  input wire logic [31:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_HALF,
  input wire logic I_REG_SUPERVISOR_ONLY,
  output logic [31:0] O_REG_RDATA,
  input wire logic I_CPU_REQ,
  input wire logic I_CPU_WRITE,
  input wire logic I_CPU_SUPERVISOR_ONLY,
  input wire logic [31:0] I_CPU_ADDR,
  input wire logic [31:0] I_CPU_WDATA,
  output logic O_CPU_ACK,
  output logic O_CPU_ILLEGAL,
  output logic [17:0] O_MEM_SEL,
  output logic [15:0] O_PERIPH_SEL,
  output logic O_PERIPH_EXT,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  output logic O_MEM_WE,
  output logic O_MEM_RE,
  output logic [1:0] O_MEM_WIDTH,
  output logic O_PFLASH_SEL,
  output logic O_DFLASH_SEL
);
  localparam int NM = msd_pkg::NUM_MSEL;
  localparam int NP = msd_pkg::NUM_PROG;
  localparam int NS = msd_pkg::NUM_PSEL;

  initial begin
    if (PSEL_TAG == 18'h3_ffff) $error("peripheral window overlaps registers");
  end

  logic [15:0] static_memory_timing_reg;
  logic [15:0] write_posting_control_reg;
  logic [15:0] peripheral_write_control_reg;
  logic [15:0] peripheral_external_map_reg;
  logic [15:0] pprot_reg;
  logic [15:0] hi_reg [0:NP];
  logic [15:0] lo_reg [0:NP-1];
  logic endian_s1_reg;
  logic endian_s2_reg;

  // register write path
  logic wr_ok;
  logic [15:0] wd;
  assign wr_ok = I_REG_WR && I_REG_HALF && I_REG_SUPERVISOR_ONLY;
  assign wd = I_REG_WDATA[15:0];

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      static_memory_timing_reg <= msd_pkg::RST_ZERO;
    end else if (wr_ok && (I_REG_ADDR == msd_pkg::OFS_STATIC_MEMORY_TIMING)) begin
      // a reserved width code leaves the old width in place
      if (wd[msd_pkg::WIDTH_LSB +: 2] == msd_pkg::WIDTH_RSVD) begin
        static_memory_timing_reg <= (wd & msd_pkg::WMASK_STATIC_MEMORY_TIMING & 16'hfffc) |
                      (static_memory_timing_reg & 16'h0003);
      end else begin
        static_memory_timing_reg <= wd & msd_pkg::WMASK_STATIC_MEMORY_TIMING;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      write_posting_control_reg <= msd_pkg::RST_ZERO;
      peripheral_write_control_reg <= msd_pkg::RST_ZERO;
    end else if (wr_ok) begin
      if (I_REG_ADDR == msd_pkg::OFS_WRITE_POSTING_CONTROL) begin
        write_posting_control_reg <= wd & msd_pkg::WMASK_WRITE_POSTING_CONTROL;
      end
      if (I_REG_ADDR == msd_pkg::OFS_PERIPHERAL_WRITE_CONTROL) begin
        peripheral_write_control_reg <= wd & msd_pkg::WMASK_PERIPHERAL_WRITE_CONTROL;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      peripheral_external_map_reg <= msd_pkg::RST_ZERO;
      pprot_reg <= msd_pkg::RST_ZERO;
    end else if (wr_ok) begin
      if (I_REG_ADDR == msd_pkg::OFS_PERIPHERAL_EXTERNAL_MAP) begin
        peripheral_external_map_reg <= wd;
      end
      if (I_REG_ADDR == msd_pkg::OFS_PPROT) begin
        pprot_reg <= wd;
      end
    end
  end

  logic [31:0] hi_ofs [0:NP];
  logic [31:0] lo_ofs [0:NP-1];
  assign hi_ofs[0] = msd_pkg::OFS_HI0;
  assign hi_ofs[1] = msd_pkg::OFS_HI1;
  assign hi_ofs[2] = msd_pkg::OFS_HI2;
  assign hi_ofs[3] = msd_pkg::OFS_HI3;
  assign hi_ofs[4] = msd_pkg::OFS_HI4;
  assign lo_ofs[0] = msd_pkg::OFS_LO0;
  assign lo_ofs[1] = msd_pkg::OFS_LO1;
  assign lo_ofs[2] = msd_pkg::OFS_LO2;
  assign lo_ofs[3] = msd_pkg::OFS_LO3;

  genvar g;
  generate
    for (g = 0; g <= NP; g++) begin : g_hi
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          hi_reg[g] <= (g == NP) ? msd_pkg::RST_HI4 : msd_pkg::RST_ZERO;
        end else if (wr_ok && (I_REG_ADDR == hi_ofs[g])) begin
          hi_reg[g] <= wd;
        end
      end
    end
    for (g = 0; g < NP; g++) begin : g_lo
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          lo_reg[g] <= msd_pkg::RST_ZERO;
        end else if (wr_ok && (I_REG_ADDR == lo_ofs[g])) begin
          lo_reg[g] <= wd & ((g == 0) ? msd_pkg::WMASK_LO0 : msd_pkg::WMASK_LO);
        end
      end
    end
  endgenerate

  // byte-order strap is a pin: two stages before use
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      endian_s1_reg <= 1'b0;
      endian_s2_reg <= 1'b0;
    end else begin
      endian_s1_reg <= I_LITTLE_ENDIAN;
      endian_s2_reg <= endian_s1_reg;
    end
  end

  // register read path, data in the cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (I_REG_ADDR == msd_pkg::OFS_STATIC_MEMORY_TIMING) begin
      rd_mux = static_memory_timing_reg;
      rd_mux[msd_pkg::ENDIAN_BIT] = endian_s2_reg;
    end
    if (I_REG_ADDR == msd_pkg::OFS_WRITE_POSTING_CONTROL) rd_mux = write_posting_control_reg;
    if (I_REG_ADDR == msd_pkg::OFS_PERIPHERAL_WRITE_CONTROL) rd_mux = peripheral_write_control_reg;
    if (I_REG_ADDR == msd_pkg::OFS_PERIPHERAL_EXTERNAL_MAP) rd_mux = peripheral_external_map_reg;
    if (I_REG_ADDR == msd_pkg::OFS_PPROT) rd_mux = pprot_reg;
    for (int i = 0; i <= NP; i++) begin
      if (I_REG_ADDR == hi_ofs[i]) rd_mux = hi_reg[i];
    end
    for (int i = 0; i < NP; i++) begin
      if (I_REG_ADDR == lo_ofs[i]) rd_mux = lo_reg[i];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_REG_RDATA <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      O_REG_RDATA <= {16'h0000, rd_mux};
    end else begin
      O_REG_RDATA <= 32'h0000_0000;
    end
  end

  // address manager
  logic map_on;
  logic [21:0] base [0:NM-1];
  logic [3:0] size [0:NM-1];
  logic [NM-1:0] hit;
  assign map_on = lo_reg[0][msd_pkg::MAP_BIT];

  generate
    for (g = 0; g < NM; g++) begin : g_sel
      if (g < NP) begin : g_prog
        assign base[g] = {hi_reg[g], lo_reg[g][15:msd_pkg::BASE_LO_LSB]};
        assign size[g] = lo_reg[g][msd_pkg::SIZE_LSB +: 4];
      end else if (g == NP) begin : g_four
        assign base[g] = {hi_reg[g], 6'h00};
        assign size[g] = msd_pkg::FIXED_SIZE;
      end else begin : g_fix
        assign base[g] = {16'(g - msd_pkg::FIXED_HI_OFS), 6'h00};
        assign size[g] = msd_pkg::FIXED_SIZE;
      end
      msd_region_match u_match (
        .i_base(base[g]),
        .i_size(size[g]),
        .i_addr(I_CPU_ADDR),
        .o_hit(hit[g])
      );
    end
  endgenerate

  // lowest select wins where programmed regions overlap
  logic [NM-1:0] msel;
  logic any_m;
  logic ro_hit;
  logic supervisor_only_hit;
  logic aw_hit;
  always_comb begin
    msel = '0;
    any_m = 1'b0;
    ro_hit = 1'b0;
    supervisor_only_hit = 1'b0;
    aw_hit = 1'b0;
    for (int i = 0; i < NM; i++) begin
      if (map_on && hit[i] && !any_m) begin
        any_m = 1'b1;
        msel[i] = 1'b1;
        if (i < NP) begin
          ro_hit = lo_reg[i][msd_pkg::RO_BIT];
          supervisor_only_hit = lo_reg[i][msd_pkg::SUPERVISOR_ONLY_BIT];
          aw_hit = (i > 0) && lo_reg[i][msd_pkg::AW_BIT];
        end
      end
    end
  end

  logic in_pwin;
  logic [3:0] pidx;
  logic [NS-1:0] psel;
  assign in_pwin = !any_m && (I_CPU_ADDR[31:msd_pkg::PSEL_TAG_LSB] == PSEL_TAG);
  assign pidx = I_CPU_ADDR[msd_pkg::PSEL_IDX_LSB +: 4];
  assign psel = in_pwin ? (NS'(1) << pidx) : '0;

  logic illegal;
  always_comb begin
    illegal = 1'b0;
    if (any_m) begin
      if (ro_hit && I_CPU_WRITE) illegal = 1'b1;
      if (supervisor_only_hit && !I_CPU_SUPERVISOR_ONLY) illegal = 1'b1;
    end else if (in_pwin) begin
      if (pprot_reg[pidx] && !I_CPU_SUPERVISOR_ONLY) illegal = 1'b1;
    end
  end

  // access timing
  logic tmr_busy;
  logic tmr_strobe;
  logic tmr_done;
  logic wait_ack_reg;
  logic accept;
  logic start;
  logic post_now;
  logic [msd_pkg::CNT_W-1:0] act_cycles;
  logic [2:0] trail_field;
  logic [2:0] trail_cycles;

  // a posted write keeps the timer busy, which holds off the next request
  assign accept = I_CPU_REQ && !tmr_busy && !wait_ack_reg;
  assign start = accept && !illegal && (any_m || in_pwin);
  assign post_now = start && I_CPU_WRITE &&
                    ((any_m && write_posting_control_reg[msd_pkg::POST_BIT]) ||
                     (in_pwin && peripheral_write_control_reg[msd_pkg::POST_BIT]));

  assign act_cycles = msd_pkg::CNT_W'(static_memory_timing_reg[msd_pkg::ACTIVE_LSB +: 4])
                    + msd_pkg::CNT_W'(1)
                    + msd_pkg::CNT_W'(aw_hit && I_CPU_WRITE);
  assign trail_field = static_memory_timing_reg[msd_pkg::TRAIL_LSB +: 3];
  assign trail_cycles = (!write_posting_control_reg[msd_pkg::OVR_BIT] && (trail_field == 3'h0))
                      ? 3'h1 : trail_field;

  msd_access_timer u_timer (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .i_start(start),
    .i_write(I_CPU_WRITE),
    .i_setup(static_memory_timing_reg[msd_pkg::WRITE_SETUP_CYCLES_LSB +: 2]),
    .i_active(act_cycles),
    .i_trail(trail_cycles),
    .o_busy(tmr_busy),
    .o_strobe(tmr_strobe),
    .o_done(tmr_done)
  );

  // unmapped or illegal requests finish at once with no bus cycle
  assign O_CPU_ILLEGAL = accept && illegal;
  assign O_CPU_ACK = (accept && !start) || post_now ||
                     (wait_ack_reg && tmr_done);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      wait_ack_reg <= 1'b0;
    end else if (start && !post_now) begin
      wait_ack_reg <= 1'b1;
    end else if (tmr_done) begin
      wait_ack_reg <= 1'b0;
    end
  end

  // captured access: address, data and selects held until the cycle ends
  logic rd_cyc_reg;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_MEM_SEL <= '0;
      O_PERIPH_SEL <= '0;
      O_PERIPH_EXT <= 1'b0;
      O_MEM_ADDR <= 32'h0000_0000;
      O_MEM_WDATA <= 32'h0000_0000;
      rd_cyc_reg <= 1'b0;
    end else if (start) begin
      O_MEM_SEL <= msel;
      O_PERIPH_SEL <= psel;
      O_PERIPH_EXT <= in_pwin && peripheral_external_map_reg[pidx];
      O_MEM_ADDR <= I_CPU_ADDR;
      O_MEM_WDATA <= I_CPU_WDATA;
      rd_cyc_reg <= !I_CPU_WRITE;
    end else if (tmr_done) begin
      O_MEM_SEL <= '0;
      O_PERIPH_SEL <= '0;
      O_PERIPH_EXT <= 1'b0;
      rd_cyc_reg <= 1'b0;
    end
  end

  assign O_MEM_WE = tmr_strobe;
  assign O_MEM_RE = rd_cyc_reg;
  assign O_MEM_WIDTH = static_memory_timing_reg[msd_pkg::WIDTH_LSB +: 2];
  assign O_PFLASH_SEL = O_MEM_SEL[1];
  assign O_DFLASH_SEL = O_MEM_SEL[2];
endmodule
`default_nettype wire

// [bench/msd_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module msd_properties (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_REG_RD,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic I_CPU_REQ,
  input wire logic O_CPU_ACK,
  input wire logic O_CPU_ILLEGAL,
  input wire logic [17:0] O_MEM_SEL,
  input wire logic [15:0] O_PERIPH_SEL,
  input wire logic O_PERIPH_EXT,
  input wire logic [31:0] O_MEM_ADDR,
  input wire logic O_MEM_WE,
  input wire logic O_MEM_RE,
  input wire logic [1:0] O_MEM_WIDTH,
  input wire logic O_PFLASH_SEL,
  input wire logic O_DFLASH_SEL
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);
  rdata_idle_zero_a: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  rdata_upper_zero_a: assert property (O_REG_RDATA[31:16] == 16'h0000)
    else $error("read data uses upper lines");
  ack_needs_req_a: assert property (O_CPU_ACK |-> I_CPU_REQ)
    else $error("ack without request");
  illegal_with_ack_a: assert property (O_CPU_ILLEGAL |-> O_CPU_ACK)
    else $error("illegal without ack");
  illegal_no_cycle_a: assert property (O_CPU_ILLEGAL |=> O_MEM_SEL == '0 && O_PERIPH_SEL == '0)
    else $error("illegal access started a bus cycle");
  select_onehot_a: assert property ($onehot0(O_MEM_SEL) && $onehot0(O_PERIPH_SEL)
      && !((|O_MEM_SEL) && (|O_PERIPH_SEL)))
    else $error("more than one select active");
  flash_sel_a: assert property (O_PFLASH_SEL == O_MEM_SEL[1] && O_DFLASH_SEL == O_MEM_SEL[2])
    else $error("flash select differs from memory select");
  ext_with_psel_a: assert property (O_PERIPH_EXT |-> (|O_PERIPH_SEL))
    else $error("external flag without peripheral select");
  width_legal_a: assert property (O_MEM_WIDTH != 2'h3)
    else $error("reserved width code on output");
  read_hold_a: assert property (O_MEM_RE && !O_CPU_ACK |=> O_MEM_RE && $stable(O_MEM_ADDR)
      && $stable(O_MEM_SEL))
    else $error("read cycle ended before ack");
  strobe_excl_a: assert property (!(O_MEM_WE && O_MEM_RE))
    else $error("write and read strobe together");
endmodule
bind msd_memory_select_decode_ctrl msd_properties u_props (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
  .I_CPU_REQ(I_CPU_REQ), .O_CPU_ACK(O_CPU_ACK), .O_CPU_ILLEGAL(O_CPU_ILLEGAL),
  .O_MEM_SEL(O_MEM_SEL), .O_PERIPH_SEL(O_PERIPH_SEL), .O_PERIPH_EXT(O_PERIPH_EXT),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WE(O_MEM_WE), .O_MEM_RE(O_MEM_RE),
  .O_MEM_WIDTH(O_MEM_WIDTH), .O_PFLASH_SEL(O_PFLASH_SEL), .O_DFLASH_SEL(O_DFLASH_SEL)
);
`default_nettype wire

// [bench/msd_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module msd_cpu_model (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic i_illegal,
  input wire logic [17:0] i_mem_sel,
  input wire logic [15:0] i_periph_sel,
  input wire logic i_ext,
  output logic o_req,
  output logic o_write,
  output logic o_supervisor_only,
  output logic [31:0] o_addr,
  output logic [31:0] o_wdata
);
  int lat;
  logic ill;
  logic [17:0] msel;
  logic [15:0] psel;
  logic ext;
  initial begin
    o_req = 1'b0;
    o_write = 1'b0;
    o_supervisor_only = 1'b0;
    o_addr = 32'h0000_0000;
    o_wdata = 32'h0000_0000;
  end
  // request stays up until ack, the way a core sits in wait states
  task automatic access(input logic w, input logic p, input logic [31:0] a);
    lat = 0;
    msel = '0;
    psel = '0;
    ext = 1'b0;
    @(posedge i_clk);
    o_req <= 1'b1;
    o_write <= w;
    o_supervisor_only <= p;
    o_addr <= a;
    o_wdata <= ~a;
    for (int n = 0; n < 400; n++) begin
      @(posedge i_clk);
      msel = msel | i_mem_sel;
      psel = psel | i_periph_sel;
      ext = ext | i_ext;
      if (i_ack === 1'b1) break;
      lat++;
    end
    ill = i_illegal;
    // released bus shows inverted values so no stale match can pass
    o_req <= 1'b0;
    o_write <= ~w;
    o_addr <= ~a;
    o_wdata <= a;
  endtask
endmodule
`default_nettype wire

// [bench/msd_memory_select_decode_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module msd_memory_select_decode_ctrl_bench;
  localparam logic [31:0] RA [14] = '{msd_pkg::OFS_STATIC_MEMORY_TIMING, msd_pkg::OFS_WRITE_POSTING_CONTROL, msd_pkg::OFS_PERIPHERAL_WRITE_CONTROL,
    msd_pkg::OFS_PERIPHERAL_EXTERNAL_MAP, msd_pkg::OFS_PPROT, msd_pkg::OFS_HI0, msd_pkg::OFS_LO0, msd_pkg::OFS_HI1,
    msd_pkg::OFS_LO1, msd_pkg::OFS_HI2, msd_pkg::OFS_LO2, msd_pkg::OFS_HI3, msd_pkg::OFS_LO3,
    msd_pkg::OFS_HI4};
  localparam logic [15:0] RR [14] = '{16'h0008, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002};
  localparam logic [15:0] RM [14] = '{16'h3ef0, 16'h0003, 16'h0001, 16'hffff, 16'hffff, 16'hffff,
    16'hfdf3, 16'hffff, 16'hfef3, 16'hffff, 16'hfef3, 16'hffff, 16'hfef3, 16'hffff};
  localparam logic [31:0] A4 = 32'h0002_0100;
  localparam logic [31:0] A3 = 32'h0001_0900;
  localparam logic [31:0] PA = {18'h3_ffdf, 4'h2, 10'h000};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic little = 1'b1;
  logic [31:0] rg_addr = 32'h0000_0000;
  logic [31:0] rg_wdata = 32'h0000_0000;
  logic rg_wr = 1'b0;
  logic rg_rd = 1'b0;
  logic rg_half = 1'b0;
  logic rg_supervisor_only = 1'b0;
  logic [31:0] rg_rdata;
  logic req, wr_c, supervisor_only_c, ack, ill, ext;
  logic [31:0] caddr, cwdata;
  logic [17:0] msel;
  logic [15:0] psel;
  logic [1:0] width;
  int errors = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  msd_memory_select_decode_ctrl DUT (.I_CORE_CLK(clk), .I_NRST(nrst), .I_LITTLE_ENDIAN(little),
    .I_REG_ADDR(rg_addr), .I_REG_WDATA(rg_wdata), .I_REG_WR(rg_wr), .I_REG_RD(rg_rd),
    .I_REG_HALF(rg_half), .I_REG_SUPERVISOR_ONLY(rg_supervisor_only), .O_REG_RDATA(rg_rdata), .I_CPU_REQ(req),
    .I_CPU_WRITE(wr_c), .I_CPU_SUPERVISOR_ONLY(supervisor_only_c), .I_CPU_ADDR(caddr), .I_CPU_WDATA(cwdata),
    .O_CPU_ACK(ack), .O_CPU_ILLEGAL(ill), .O_MEM_SEL(msel), .O_PERIPH_SEL(psel),
    .O_PERIPH_EXT(ext), .O_MEM_ADDR(), .O_MEM_WDATA(), .O_MEM_WE(), .O_MEM_RE(),
    .O_MEM_WIDTH(width), .O_PFLASH_SEL(), .O_DFLASH_SEL());
  msd_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_illegal(ill), .i_mem_sel(msel),
    .i_periph_sel(psel), .i_ext(ext), .o_req(req), .o_write(wr_c), .o_supervisor_only(supervisor_only_c),
    .o_addr(caddr), .o_wdata(cwdata));
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic p = 1'b1,
                    input logic h = 1'b1);
    @(posedge clk);
    rg_wr <= 1'b1;
    rg_addr <= a;
    rg_wdata <= {~d, d};
    rg_supervisor_only <= p;
    rg_half <= h;
    @(posedge clk);
    rg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk);
    rg_rd <= 1'b1;
    rg_addr <= a;
    @(posedge clk);
    rg_rd <= 1'b0;
    #1 `CHK($sformatf("reg %h", a), {16'h0000, e}, rg_rdata)
  endtask
  task automatic acc(input logic w, input logic p, input logic [31:0] a, input int l,
                     input logic i, input logic [17:0] s);
    cpu.access(w, p, a);
    if (l >= 0) `CHK("latency", l, cpu.lat)
    `CHK("illegal", i, cpu.ill)
    `CHK("select", s, cpu.msel)
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // strap passes two sync flops before the byte-order bit shows it
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    do_reset();
    for (int k = 0; k < 14; k++) rd(RA[k], RR[k]);
    rd(32'hffff_fd04, 16'h0000);
    for (int k = 0; k < 14; k++) begin
      wr(RA[k], 16'hffff, 1'b0, 1'b1);
      wr(RA[k], 16'hffff, 1'b1, 1'b0);
      rd(RA[k], RR[k]);
      wr(RA[k], 16'hffff);
      rd(RA[k], RR[k] | RM[k]);
    end
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h0002);
    #1 `CHK("width", 2'h2, width)
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h0003);
    rd(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h000a);
    little <= 1'b0;
    repeat (3) @(posedge clk);
    rd(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h0002);
    do_reset();
    acc(1'b0, 1'b1, A4, 0, 1'b0, 18'h0_0000);
    wr(msd_pkg::OFS_LO0, 16'h0100);
    wr(msd_pkg::OFS_HI3, 16'h0001);
    wr(msd_pkg::OFS_LO3, 16'h0810);
    acc(1'b0, 1'b1, A4, 2, 1'b0, 18'h0_0010);
    acc(1'b0, 1'b1, 32'h0001_0bfc, 2, 1'b0, 18'h0_0008);
    acc(1'b0, 1'b1, 32'h0001_0c00, 0, 1'b0, 18'h0_0000);
    acc(1'b0, 1'b1, 32'h0001_07fc, 0, 1'b0, 18'h0_0000);
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h00f0);
    wr(msd_pkg::OFS_WRITE_POSTING_CONTROL, 16'h0002);
    acc(1'b0, 1'b1, A4, 16, 1'b0, 18'h0_0010);
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h0a30);
    wr(msd_pkg::OFS_WRITE_POSTING_CONTROL, 16'h0000);
    acc(1'b0, 1'b1, A4, 9, 1'b0, 18'h0_0010);
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h3020);
    wr(msd_pkg::OFS_WRITE_POSTING_CONTROL, 16'h0002);
    acc(1'b1, 1'b1, A4, 6, 1'b0, 18'h0_0010);
    acc(1'b0, 1'b1, A4, 3, 1'b0, 18'h0_0010);
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h0000);
    acc(1'b1, 1'b1, A3, 1, 1'b0, 18'h0_0008);
    wr(msd_pkg::OFS_LO3, 16'h0a10);
    acc(1'b1, 1'b1, A3, 2, 1'b0, 18'h0_0008);
    wr(msd_pkg::OFS_STATIC_MEMORY_TIMING, 16'h00f0);
    wr(msd_pkg::OFS_WRITE_POSTING_CONTROL, 16'h0003);
    acc(1'b1, 1'b1, A4, 0, 1'b0, 18'h0_0000);
    acc(1'b0, 1'b1, A4, -1, 1'b0, 18'h0_0010);
    `CHK("stall", 1'b1, cpu.lat > 16)
    wr(msd_pkg::OFS_PERIPHERAL_EXTERNAL_MAP, 16'h0004);
    wr(msd_pkg::OFS_PPROT, 16'h0004);
    acc(1'b0, 1'b0, PA, 0, 1'b1, 18'h0_0000);
    acc(1'b0, 1'b1, PA, -1, 1'b0, 18'h0_0000);
    `CHK("psel", 16'h0004, cpu.psel)
    `CHK("ext", 1'b1, cpu.ext)
    acc(1'b1, 1'b1, PA, -1, 1'b0, 18'h0_0000);
    `CHK("unposted", 1'b1, cpu.lat > 0)
    wr(msd_pkg::OFS_PERIPHERAL_WRITE_CONTROL, 16'h0001);
    acc(1'b1, 1'b1, PA, 0, 1'b0, 18'h0_0000);
    // let the posted peripheral write drain so the next request is taken at once
    repeat (20) @(posedge clk);
    wr(msd_pkg::OFS_LO3, 16'h0812);
    acc(1'b1, 1'b1, A3, 0, 1'b1, 18'h0_0000);
    acc(1'b0, 1'b1, A3, -1, 1'b0, 18'h0_0008);
    wr(msd_pkg::OFS_LO3, 16'h0811);
    acc(1'b0, 1'b0, A3, 0, 1'b1, 18'h0_0000);
    acc(1'b0, 1'b1, A3, -1, 1'b0, 18'h0_0008);
    end_of_test();
  end
endmodule
`default_nettype wire
